// ===== logic/dssp_pkg.sv
// constants and types for the statistics serial port of the video codec
// assumes: host side on clk_i, link side on the video clock, shared reset
//
// Overview of operation
// RULE_01 - sync pulse one bit before first bit
// RULE_02 - transmit frame is 52 words of 16
// RULE_03 - processor raises receive sync before frame
// RULE_04 - capture all 84 received 16-bit words
// RULE_05 - sync high and low last a bit
// RULE_06 - interrupt low through send and receive
// RULE_07 - interrupt falls when statistics sending starts
// RULE_08 - processor should treat interrupt as edge
// RULE_09 - processor frames on our sync, sends own
// RULE_10 - exchange runs only when processor present
// RULE_11 - bit clock is video clock over four
// RULE_12 - launch after rise, sample at fall
// RULE_13 - words are 16 bits, msb first
// RULE_14 - transmit words back to back, no gaps
package dssp_pkg;

	// ------------------------------------------------------------
	// frame geometry
	// ------------------------------------------------------------
	localparam int WORD_BITS  = 16;
	localparam int TX_SLOTS   = 52;
	localparam int RX_SLOTS   = 84;
	localparam int TX_BITS    = TX_SLOTS * WORD_BITS;
	localparam int RX_BITS    = RX_SLOTS * WORD_BITS;
	localparam int TX_IDX_W   = 6;
	localparam int RX_IDX_W   = 7;
	localparam int TX_CNT_W   = 10;
	localparam int RX_CNT_W   = 11;

	// ------------------------------------------------------------
	// bit clock divider and phases (video clock cycles)
	// ------------------------------------------------------------
	localparam int          DIV_W       = 2;
	localparam logic [1:0]  PH_LAUNCH   = 2'h0;
	localparam logic [1:0]  PH_FALL_PRE = 2'h1;
	localparam logic [1:0]  PH_SAMPLE   = 2'h3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic        IRQ_N_RST = 1'b1;
	localparam logic        FS_RST    = 1'b0;
	localparam logic        SBC_RST   = 1'b0;
	localparam logic        TXD_RST   = 1'b0;
	// divider starts in the low half so the first bit clock high lasts two cycles
	localparam logic [1:0]  DIV_RST   = PH_FALL_PRE;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_SYNC,
		TX_DATA,
		TX_WAIT
	} dssp_tx_state_t;

endpackage

// ===== logic/dssp_sync.sv
// two flip-flop level synchroniser, any width
// assumes: inputs are quasi static or independent single bits
`timescale 1ns/1ps
module dssp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// data
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule // dssp_sync

// ===== logic/dssp_pulse_cdc.sv
// single pulse crossing by toggle, source to destination clock
// assumes: source pulses are at least three destination cycles apart
`timescale 1ns/1ps
module dssp_pulse_cdc (
	// source side
	input  wire logic src_clk_i,
	input  wire logic src_pulse_i,
	// destination side
	input  wire logic dst_clk_i,
	output logic      dst_pulse_o,
	// shared reset
	input  wire logic rstn_i
);

	logic tog_q;
	logic meta_q;
	logic sync_q;
	logic last_q;

	// toggle carries the event; a level survives any clock ratio
	always_ff @(posedge src_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			tog_q <= 1'b0;
		else if (src_pulse_i)
			tog_q <= ~tog_q;
	end

	// resync then edge detect on the second stage only
	always_ff @(posedge dst_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q      <= 1'b0;
			sync_q      <= 1'b0;
			last_q      <= 1'b0;
			dst_pulse_o <= 1'b0;
		end else begin
			meta_q      <= tog_q;
			sync_q      <= meta_q;
			last_q      <= sync_q;
			dst_pulse_o <= sync_q ^ last_q;
		end
	end

endmodule // dssp_pulse_cdc

// ===== logic/dssp_serial_port.sv
// statistics / bin width serial port toward an optional signal processor
// assumes: host loads statistics words then pulses start; reads bin widths
// after the ready pulse; video_clk_i free running; rstn_i held long enough
`timescale 1ns/1ps
module dssp_serial_port
	import dssp_pkg::*;
(
	// host clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rstn_i,
	// host mode setting
	input  wire logic                          dsp_present_i,
	// host statistics load and start
	input  wire logic                          stats_wr_i,
	input  wire logic [dssp_pkg::TX_IDX_W-1:0] stats_addr_i,
	input  wire logic [dssp_pkg::WORD_BITS-1:0] stats_wdata_i,
	input  wire logic                          stats_start_i,
	// host bin width readback
	input  wire logic [dssp_pkg::RX_IDX_W-1:0] bw_rd_addr_i,
	output logic      [dssp_pkg::WORD_BITS-1:0] bw_rdata_o,
	output logic                               bw_ready_o,
	output logic                               exchange_busy_o,
	// link clock
	input  wire logic                          video_clk_i,
	// serial pins
	output logic                               serial_bit_clock_o,
	output logic                               tx_frame_sync_o,
	output logic                               serial_tx_data_o,
	input  wire logic                          serial_rx_data_i,
	input  wire logic                          rx_frame_sync_i,
	output logic                               stats_irq_n_o
);

	import dssp_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [WORD_BITS-1:0] tx_mem [TX_SLOTS];
	logic [WORD_BITS-1:0] rx_mem [RX_SLOTS];

	logic [DIV_W-1:0]     div_q;
	logic                 sbc_d;
	logic                 launch;
	logic                 sample;
	logic                 start_v;
	logic                 start_pend_q;
	logic                 rx_done_q;
	logic                 rx_seen_q;
	logic                 done_h;
	logic [2:0]           pins_v;
	logic                 rxd_v;
	logic                 rfs_v;
	logic                 present_v;
	dssp_tx_state_t       tx_st_q;
	logic [TX_CNT_W-1:0]  tx_bit_q;
	logic [TX_CNT_W-1:0]  tx_nbit;
	logic [WORD_BITS-1:0] tx_nword;
	logic                 tx_nlast;
	logic                 rx_act_q;
	logic                 rfs_prev_q;
	logic [RX_CNT_W-1:0]  rx_bit_q;
	logic [WORD_BITS-1:0] rx_shift_q;
	logic [WORD_BITS-1:0] rx_word;
	logic                 rfs_rise;
	logic                 rx_word_end;
	logic                 rx_frame_end;
	logic                 busy_v;

	// ------------------------------------------------------------
	// host domain: statistics store and readback
	// ------------------------------------------------------------
	// host must not rewrite statistics while the exchange is busy
	always_ff @(posedge clk_i) begin
		if (stats_wr_i && stats_addr_i < TX_IDX_W'(TX_SLOTS))
			tx_mem[stats_addr_i] <= stats_wdata_i;
	end

	// registered read; words are stable once bw_ready_o has pulsed
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bw_rdata_o <= '0;
			bw_ready_o <= 1'b0;
		end else begin
			bw_rdata_o <= (bw_rd_addr_i < RX_IDX_W'(RX_SLOTS)) ? rx_mem[bw_rd_addr_i] : '0;
			bw_ready_o <= done_h;
		end
	end

	// ------------------------------------------------------------
	// crossings
	// ------------------------------------------------------------
	dssp_pulse_cdc u_start_cdc (
		.src_clk_i   (clk_i),
		.src_pulse_i (stats_start_i),
		.dst_clk_i   (video_clk_i),
		.dst_pulse_o (start_v),
		.rstn_i      (rstn_i)
	);

	dssp_pulse_cdc u_done_cdc (
		.src_clk_i   (video_clk_i),
		.src_pulse_i (rx_done_q),
		.dst_clk_i   (clk_i),
		.dst_pulse_o (done_h),
		.rstn_i      (rstn_i)
	);

	// pins and the mode level enter the link domain through two stages
	dssp_sync #(.WIDTH(3)) u_pin_sync (
		.clk_i  (video_clk_i),
		.rstn_i (rstn_i),
		.d_i    ({dsp_present_i, rx_frame_sync_i, serial_rx_data_i}),
		.q_o    (pins_v)
	);

	assign present_v = pins_v[2];
	assign rfs_v     = pins_v[1];
	assign rxd_v     = pins_v[0];

	// busy level for the host, straight from the synchroniser flop
	dssp_sync #(.WIDTH(1)) u_busy_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.d_i    (~stats_irq_n_o),
		.q_o    (busy_v)
	);

	assign exchange_busy_o = busy_v;

	// ------------------------------------------------------------
	// bit clock generation
	// ------------------------------------------------------------
	// high for phases 0 and 1, rises on the 3->0 edge
	assign sbc_d  = (div_q == PH_SAMPLE) || (div_q == PH_LAUNCH);
	// launch one video clock after the rise, data then settles before the fall
	assign launch = (div_q == PH_LAUNCH);
	// synced pins at phase 3 hold the level seen at the fall edge
	assign sample = (div_q == PH_SAMPLE);

	always_ff @(posedge video_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_q              <= DIV_RST;
			serial_bit_clock_o <= SBC_RST;
		end else begin
			div_q              <= div_q + DIV_W'(1); // RULE_11
			serial_bit_clock_o <= sbc_d; // RULE_11
		end
	end

	// ------------------------------------------------------------
	// transmit framer
	// ------------------------------------------------------------
	assign tx_nbit  = tx_bit_q + TX_CNT_W'(1);
	assign tx_nword = tx_mem[tx_nbit[TX_CNT_W-1:4]];
	assign tx_nlast = (tx_bit_q == TX_CNT_W'(TX_BITS - 1));

	// start request waits for the next bit boundary; set wins over clear
	always_ff @(posedge video_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			start_pend_q <= 1'b0;
		else if (start_v)
			start_pend_q <= 1'b1;
		else if (launch && tx_st_q == TX_IDLE)
			start_pend_q <= 1'b0;
	end

	// remembers a finished receive frame until the exchange closes
	always_ff @(posedge video_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rx_seen_q <= 1'b0;
		else if (rx_done_q)
			rx_seen_q <= 1'b1;
		else if (tx_st_q == TX_IDLE)
			rx_seen_q <= 1'b0;
	end

	// frame sequence: sync bit, 832 data bits, then wait for bin widths
	always_ff @(posedge video_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_st_q          <= TX_IDLE;
			tx_bit_q         <= '0;
			tx_frame_sync_o  <= FS_RST;
			serial_tx_data_o <= TXD_RST;
			stats_irq_n_o    <= IRQ_N_RST;
		end else if (launch) begin
			case (tx_st_q)
				TX_IDLE: begin
					if (start_pend_q && present_v) begin // RULE_10
						tx_frame_sync_o <= 1'b1; // RULE_01
						stats_irq_n_o   <= 1'b0; // RULE_07
						tx_st_q         <= TX_SYNC;
					end
				end
				TX_SYNC: begin
					tx_frame_sync_o  <= 1'b0; // RULE_05
					tx_bit_q         <= '0;
					serial_tx_data_o <= tx_mem[0][WORD_BITS-1]; // RULE_13
					tx_st_q          <= TX_DATA;
				end
				TX_DATA: begin
					if (tx_nlast) begin // RULE_02
						serial_tx_data_o <= TXD_RST;
						tx_st_q          <= TX_WAIT;
					end else begin
						tx_bit_q         <= tx_nbit; // RULE_14
						serial_tx_data_o <= tx_nword[~tx_nbit[3:0]]; // RULE_13
					end
				end
				TX_WAIT: begin
					if (rx_seen_q || rx_done_q) begin
						stats_irq_n_o <= 1'b1; // RULE_06
						tx_st_q       <= TX_IDLE;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// receive capture
	// ------------------------------------------------------------
	// frame sync seen high at this fall, low at the previous one
	assign rfs_rise     = rfs_v && !rfs_prev_q; // RULE_03
	assign rx_word      = {rx_shift_q[WORD_BITS-2:0], rxd_v};
	assign rx_word_end  = (rx_bit_q[3:0] == 4'hf);
	assign rx_frame_end = (rx_bit_q == RX_CNT_W'(RX_BITS - 1));

	always_ff @(posedge video_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rfs_prev_q <= 1'b0;
			rx_act_q   <= 1'b0;
			rx_bit_q   <= '0;
			rx_shift_q <= '0;
			rx_done_q  <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			if (sample) begin
				rfs_prev_q <= rfs_v;
				if (rx_act_q) begin
					rx_shift_q <= rx_word; // RULE_12
					rx_bit_q   <= rx_bit_q + RX_CNT_W'(1);
					if (rx_frame_end) begin
						rx_act_q  <= 1'b0;
						rx_done_q <= 1'b1; // RULE_04
					end
				end else if (rfs_rise && present_v) begin // RULE_10
					rx_act_q <= 1'b1;
					rx_bit_q <= '0;
				end
			end
		end
	end

	// word store; a sync edge inside a frame is ignored until the frame ends
	always_ff @(posedge video_clk_i) begin
		if (sample && rx_act_q && rx_word_end)
			rx_mem[rx_bit_q[RX_CNT_W-1:4]] <= rx_word; // RULE_04
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_sync_bit;
		tx_frame_sync_o [*4];
	endsequence

	sequence s_half_high;
		serial_bit_clock_o [*2];
	endsequence

	a_fs_before_data: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_01
		$rose(tx_frame_sync_o) |-> ##4 (tx_st_q == TX_DATA && !tx_frame_sync_o && tx_bit_q == '0))
		else $error("first bit not one bit period after sync");

	a_tx_frame_len: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_02
		(tx_st_q == TX_DATA && launch && tx_bit_q == TX_CNT_W'(TX_BITS - 1)) |=> tx_st_q == TX_WAIT)
		else $error("transmit frame length wrong");

	a_fs_width: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_05
		$rose(tx_frame_sync_o) |-> s_sync_bit ##1 !tx_frame_sync_o [*4])
		else $error("sync high or low shorter than one bit");

	a_irq_held_low: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_06
		(tx_st_q != TX_IDLE) |-> !stats_irq_n_o)
		else $error("interrupt released mid exchange");

	a_irq_at_start: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_07
		$fell(stats_irq_n_o) |-> $rose(tx_frame_sync_o))
		else $error("interrupt not tied to packet start");

	a_present_gates: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_10
		(!present_v && tx_st_q == TX_IDLE) |=> tx_st_q == TX_IDLE)
		else $error("exchange started without processor");

	a_bit_clk_quarter: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_11
		$rose(serial_bit_clock_o) |-> s_half_high ##1 !serial_bit_clock_o [*2] ##1 serial_bit_clock_o)
		else $error("bit clock not a quarter of video clock");

	a_tx_after_rise: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_12
		$changed(serial_tx_data_o) |-> serial_bit_clock_o && $past(serial_bit_clock_o))
		else $error("transmit data changed away from rise");

	a_rx_frame_len: assert property (@(posedge video_clk_i) disable iff (!rstn_i) // RULE_04
		$rose(rx_done_q) |-> $past(rx_bit_q) == RX_CNT_W'(RX_BITS - 1))
		else $error("receive frame not 84 words");

endmodule // dssp_serial_port

// ===== tb/dssp_proc_model.sv
// behavioural model of the external signal processor serial port
// assumes: bit clock and transmit framing come from the port under test
`timescale 1ns/1ps
module dssp_proc_model (
	// serial pins seen from the processor
	input  wire logic serial_bit_clock_i,
	input  wire logic tx_frame_sync_i,
	input  wire logic serial_tx_data_i,
	input  wire logic stats_irq_n_i,
	output logic      serial_rx_data_o,
	output logic      rx_frame_sync_o,
	// bench control
	input  wire logic send_i,
	output logic      rx_active_o
);
	// ------------------------------------------------------------
	// capture and send state
	// ------------------------------------------------------------
	logic [15:0] tx_words [0:51];
	int          tx_bits   = -1;
	int          fs_len    = 0;
	int          fs_max    = 0;
	int          irq_edges = 0;
	int          rx_bit    = -1;
	int          w;
	logic [15:0] cur;

	initial begin
		serial_rx_data_o = 1'b0;
		rx_frame_sync_o  = 1'b0;
	end
	assign rx_active_o = (rx_bit >= 0);

	// receive framing follows the port's sync; bits taken at the fall
	always @(negedge serial_bit_clock_i) begin
		if (tx_bits >= 0 && tx_bits < 832) begin
			tx_words[tx_bits/16] = {tx_words[tx_bits/16][14:0], serial_tx_data_i};
			tx_bits++;
		end
		fs_len = (tx_frame_sync_i === 1'b1) ? fs_len + 1 : 0;
		fs_max = (fs_len > fs_max) ? fs_len : fs_max;
		if (fs_len == 1) tx_bits = 0;
	end

	// own framing on send; an idle data line toggles so a stale bit never passes
	always @(posedge serial_bit_clock_i) begin
		if (rx_bit < 0) begin
			serial_rx_data_o <= ~serial_rx_data_o;
			if (send_i === 1'b1) begin
				rx_frame_sync_o <= 1'b1;
				rx_bit = 0;
			end
		end else begin
			w   = rx_bit / 16;
			cur = {w[7:0], ~w[7:0]};
			rx_frame_sync_o  <= 1'b0;
			serial_rx_data_o <= cur[15 - rx_bit % 16];
			rx_bit = (rx_bit == 1343) ? -1 : rx_bit + 1;
		end
	end

	// interrupt taken on its edge; the line stays low all exchange
	always @(negedge stats_irq_n_i) irq_edges++;
endmodule // dssp_proc_model

// ===== tb/dssp_serial_port_tb.sv
// self-checking bench for the statistics serial port
// assumes: package, design and processor model compiled before this file
`timescale 1ns/1ps
module dssp_serial_port_tb;
	import dssp_pkg::*;
	// ------------------------------------------------------------
	// clocks, pins and counters
	// ------------------------------------------------------------
	logic                 clk_i         = 1'b0;
	logic                 video_clk_i   = 1'b0;
	logic                 rstn_i        = 1'b0;
	logic                 dsp_present_i = 1'b0;
	logic                 stats_wr_i    = 1'b0;
	logic [TX_IDX_W-1:0]  stats_addr_i  = '0;
	logic [WORD_BITS-1:0] stats_wdata_i = '0;
	logic                 stats_start_i = 1'b0;
	logic [RX_IDX_W-1:0]  bw_rd_addr_i  = '0;
	logic                 send          = 1'b0;
	logic [WORD_BITS-1:0] bw_rdata_o;
	logic                 bw_ready_o, exchange_busy_o, serial_bit_clock_o;
	logic                 tx_frame_sync_o, serial_tx_data_o, stats_irq_n_o;
	logic                 serial_rx_data_i, rx_frame_sync_i, rx_active;
	int                   bad_count = 0;
	int                   tests_run = 0;

	// video clock edges never meet the host clock rising edges
	always #5 clk_i = ~clk_i;
	always #80 video_clk_i = ~video_clk_i;

	dssp_serial_port dut (.clk_i, .rstn_i, .dsp_present_i, .stats_wr_i, .stats_addr_i,
		.stats_wdata_i, .stats_start_i, .bw_rd_addr_i, .bw_rdata_o, .bw_ready_o,
		.exchange_busy_o, .video_clk_i, .serial_bit_clock_o, .tx_frame_sync_o,
		.serial_tx_data_o, .serial_rx_data_i, .rx_frame_sync_i, .stats_irq_n_o);

	dssp_proc_model proc (.serial_bit_clock_i(serial_bit_clock_o), .tx_frame_sync_i(tx_frame_sync_o),
		.serial_tx_data_i(serial_tx_data_o), .stats_irq_n_i(stats_irq_n_o),
		.serial_rx_data_o(serial_rx_data_i), .rx_frame_sync_o(rx_frame_sync_i),
		.send_i(send), .rx_active_o(rx_active));

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] tx_word(input int i);
		return {8'h3c ^ i[7:0], i[7:0]};
	endfunction

	function automatic logic [15:0] rx_word(input int i);
		return {i[7:0], ~i[7:0]};
	endfunction

	task automatic check(input logic ok, input string what);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input int a, input logic [15:0] d);
		@(posedge clk_i);
		stats_wr_i    <= 1'b1;
		stats_addr_i  <= a[TX_IDX_W-1:0];
		stats_wdata_i <= d;
		@(posedge clk_i);
		stats_wr_i <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_idle;
		@(posedge clk_i);
		#1;
		check(stats_irq_n_o === 1'b1 && tx_frame_sync_o === 1'b0 && exchange_busy_o === 1'b0, "not idle");
	endtask

	task automatic t_bitclk;
		time t0, t1;
		@(posedge serial_bit_clock_o);
		t0 = $time;
		@(negedge serial_bit_clock_o);
		t1 = $time;
		@(posedge serial_bit_clock_o);
		check(t1 - t0 == 320 && $time - t0 == 640, "bit clock rate");
	endtask

	// start while no processor is fitted is dropped, nothing on the pins
	task automatic t_absent;
		for (int i = 0; i < TX_SLOTS; i++) wr(i, tx_word(i));
		wr(TX_SLOTS, 16'hffff);
		@(posedge clk_i);
		stats_start_i <= 1'b1;
		@(posedge clk_i);
		stats_start_i <= 1'b0;
		repeat (50) @(posedge video_clk_i);
		#1;
		check(stats_irq_n_o === 1'b1 && proc.fs_max == 0, "exchange without processor");
	endtask

	// receive frame overlaps the send; interrupt spans both
	task automatic t_exchange;
		int n;
		@(posedge clk_i);
		dsp_present_i <= 1'b1;
		// let the mode level through its link stages, then ask again
		repeat (64) @(posedge clk_i);
		stats_start_i <= 1'b1;
		@(posedge clk_i);
		stats_start_i <= 1'b0;
		n = 0;
		while (stats_irq_n_o !== 1'b0 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		check(n < 400 && tx_frame_sync_o === 1'b1, "interrupt not with frame sync");
		repeat (4) @(posedge clk_i);
		check(exchange_busy_o === 1'b1, "busy not raised");
		send <= 1'b1;
		n = 0;
		while (proc.tx_bits < TX_BITS && n < 4000) begin
			@(negedge video_clk_i);
			n++;
			if (rx_active) send <= 1'b0;
			check(stats_irq_n_o === 1'b0, "interrupt high during send");
		end
		check(proc.fs_max == 1, "frame sync width");
		for (int i = 0; i < TX_SLOTS; i++)
			check(proc.tx_words[i] === tx_word(i), "statistics word on wire");
		n = 0;
		while (bw_ready_o !== 1'b1 && n < 60000) begin
			@(posedge clk_i);
			#1;
			n++;
			if (rx_active) check(stats_irq_n_o === 1'b0, "interrupt high during receive");
		end
		check(n < 60000 && stats_irq_n_o === 1'b1, "exchange did not close");
		for (int i = 0; i < RX_SLOTS; i++) begin
			@(posedge clk_i);
			bw_rd_addr_i <= i[RX_IDX_W-1:0];
			@(posedge clk_i);
			#1;
			check(bw_rdata_o === rx_word(i), "bin width word");
		end
		check(proc.irq_edges == 1, "interrupt edge count");
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge video_clk_i);
		@(posedge clk_i);
		rstn_i <= 1'b1;
		t_idle();
		t_bitclk();
		t_absent();
		t_exchange();
		stop_test();
	end

	// the whole exchange needs about 0.88 ms; limit stays near 100k host cycles
	initial begin
		#1_000_000;
		bad_count++;
		stop_test();
	end
endmodule // dssp_serial_port_tb
